/* File: hw/dma_pkg.sv */
// Shared constants and types for the two-channel bus-master DMA engine.
package dma_pkg;

   // ------------------------------------------------------------
   // Buffer geometry and counts.
   // ------------------------------------------------------------
   localparam int          BUF_WORDS = 32;             // 128 bytes as 32-bit words.
   localparam int          COUNT_W   = 24;             // Width of the byte counters.
   localparam logic [5:0]  BUF_FULL  = 6'h20;          // Level of a full buffer.
   localparam logic [5:0]  THR_LOW   = 6'h04;          // Small threshold in words.
   localparam logic [5:0]  THR_HIGH  = 6'h10;          // Large threshold in words.
   localparam int          BUS_PCI   = 0;              // Bus index of the PCI side.
   localparam int          BUS_LOCAL = 1;              // Bus index of the local side.

   // ------------------------------------------------------------
   // Register map, byte addresses on the register port.
   // ------------------------------------------------------------
   localparam logic [7:0]  OFF_CTRL       = 8'h00;     // channel_control_reg.
   localparam logic [7:0]  OFF_HOST       = 8'h04;     // host_side_address.
   localparam logic [7:0]  OFF_LOCAL      = 8'h08;     // local_side_address.
   localparam logic [7:0]  OFF_COUNT      = 8'h0C;     // transfer_byte_count.
   localparam logic [7:0]  OFF_CH_MASK    = 8'h1F;     // Offset bits inside a channel.
   localparam logic [7:0]  OFF_CH_LIMIT   = 8'h40;     // Two channels, 0x20 apart.
   localparam int          CH_SEL_BIT     = 5;         // Address bit picking the channel.
   localparam logic [7:0]  OFF_SERIAL_CFG = 8'h40;     // serial_config_reg.
   localparam int          CTRL_START_BIT = 0;         // Start/stop control bit.
   localparam int          CTRL_DIR_BIT   = 1;         // Direction control bit.
   localparam int          CTRL_LEVEL_LSB = 8;         // Buffer level read field.
   localparam int          THR_SEL_LSB    = 1;         // threshold_select_lo position.
   localparam logic [1:0]  THR_4_16       = 2'b01;     // PCI 4, local 16.
   localparam logic [1:0]  THR_16_4       = 2'b10;     // PCI 16, local 4.

   typedef enum logic [2:0] {SEL_CTRL, SEL_HOST, SEL_LOCAL, SEL_COUNT, SEL_CFG,
                             SEL_NONE} reg_sel_t;
   typedef enum logic [1:0] {BUS_IDLE, BUS_REQ, BUS_XFER} bus_state_t;

   // ------------------------------------------------------------
   // Carriers.
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  addr;   logic [31:0] wdata;   logic wr;   logic rd;
   } reg_req_t;
   typedef struct packed {
      logic [31:0] addr;   logic [3:0] be;   logic write;   logic [31:0] wdata;
      logic        valid;
   } bus_cmd_t;
   typedef struct packed {
      logic ack;   logic stop;   logic [31:0] rdata;
   } bus_rsp_t;
   typedef struct packed {
      logic [2:0] n;   logic [31:0] data;
   } buf_entry_t;
   typedef struct packed {
      logic start;   logic dir;   logic [1:0][31:0] addr;   logic [COUNT_W-1:0] byteCount;
      logic [COUNT_W-1:0] srcLeft;   logic [COUNT_W-1:0] dstLeft;   logic [1:0] fillOff;
      logic [4:0] wptr;   logic [4:0] rptr;   logic [5:0] level;
   } chan_t;
   typedef struct packed {
      bus_state_t st;   logic owner;   logic lastOwner;   logic flush;   logic req;
      logic [2:0] n;   bus_cmd_t cmd;
   } bus_t;
   typedef struct packed {
      chan_t [1:0] ch;   bus_t [1:0] bus;   logic [1:0] thrSel;   logic [31:0] regRdata;
   } state_t;
   localparam state_t STATE_RESET = '0;

endpackage

/* File: hw/dual_channel_bus_master_dma.sv */
// Two-channel bus-master DMA engine moving data between the PCI and local buses.
//
// Notes on behaviour
// - Two channels, each with 128-byte buffer.
// - Buffer fills and flushes at once.
// - Active channel requests bus when threshold met.
// - Thresholds count free or filled locations.
// - Select 00=4/4, 01=4/16, 10=16/4.
// - Threshold select from config loader or software.
// - Control bit 0 starts, bit 1 direction.
// - PCI-to-local requests PCI immediately, reads until full.
// - Release PCI when full or count zero.
// - Flush to local after threshold, until done.
// - Local-to-PCI reads local until full or done.
// - Request PCI after threshold buffered, write host.
// - Refill from local after threshold flushed.
// - Flush PCI until empty, repeat until done.
// - Local bus goes alternately to pending channel.
// - PCI ownership alternates, also after retry.
// - PCI phases move the most bytes possible.
// - Odd-address local write uses upper lanes.
// - Local reads whole word, lanes all on.
`timescale 1ns/100ps

module dual_channel_bus_master_dma (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire dma_pkg::reg_req_t regReq,
   output logic [31:0]            regRdata,
   input  wire logic              cfgLoad,
   input  wire logic [1:0]        cfgThrSel,
   output logic                   pciReq,
   input  wire logic              pciGnt,
   output dma_pkg::bus_cmd_t      pciCmd,
   input  wire dma_pkg::bus_rsp_t pciRsp,
   output logic                   locReq,
   input  wire logic              localGrantAckN,
   output dma_pkg::bus_cmd_t      locCmd,
   input  wire dma_pkg::bus_rsp_t locRsp
);

   // ------------------------------------------------------------
   // Helper functions.
   // ------------------------------------------------------------

   // Register decode, shared by the write and the read path.
   function automatic dma_pkg::reg_sel_t regSel(input logic [7:0] a);
      regSel = dma_pkg::SEL_NONE;
      if (a == dma_pkg::OFF_SERIAL_CFG) begin
         regSel = dma_pkg::SEL_CFG;
      end else if (a < dma_pkg::OFF_CH_LIMIT) begin
         case (a & dma_pkg::OFF_CH_MASK)
            dma_pkg::OFF_CTRL:  regSel = dma_pkg::SEL_CTRL;
            dma_pkg::OFF_HOST:  regSel = dma_pkg::SEL_HOST;
            dma_pkg::OFF_LOCAL: regSel = dma_pkg::SEL_LOCAL;
            dma_pkg::OFF_COUNT: regSel = dma_pkg::SEL_COUNT;
            default:            regSel = dma_pkg::SEL_NONE;
         endcase
      end
   endfunction

   // Most bytes one phase may move: limited by both alignments and what is left.
   function automatic logic [2:0] phaseBytes(input logic [1:0] srcOff,
                                             input logic [1:0] dstOff,
                                             input logic [23:0] left);
      logic [2:0] n;
      n = 3'h4 - {1'b0, srcOff};
      if (3'h4 - {1'b0, dstOff} < n) begin
         n = 3'h4 - {1'b0, dstOff};
      end
      if (left < 24'(n)) begin
         n = left[2:0];
      end
      phaseBytes = n;
   endfunction

   // Byte lanes for n bytes starting at lane off.
   function automatic logic [3:0] laneMask(input logic [2:0] n, input logic [1:0] off);
      laneMask = 4'(((4'hF >> (3'h4 - n)) << off));
   endfunction

   // ------------------------------------------------------------
   // State, buffer memory and combinational helpers.
   // ------------------------------------------------------------
   dma_pkg::state_t     st_r;                        // All control state.
   dma_pkg::state_t     st_nxt;                      // Its next value.
   dma_pkg::buf_entry_t bufMem [2][dma_pkg::BUF_WORDS]; // One private buffer per channel.
   logic [1:0]          memWe;                       // Buffer write per channel.
   logic [4:0]          memIdx  [2];                 // Buffer write location.
   dma_pkg::buf_entry_t memData [2];                 // Buffer write value.
   dma_pkg::buf_entry_t rdEnt;                       // Entry being flushed.
   logic [1:0]          push;                        // Word entered a buffer.
   logic [1:0]          pop;                         // Word left a buffer.
   logic [1:0]          want    [2];                 // Channel wants bus, per bus.
   logic [5:0]          thr     [2];                 // Threshold per bus in words.
   logic [5:0]          freeW   [2];                 // Free locations per channel.
   logic                gnt     [2];                 // Grant per bus, active high.
   dma_pkg::bus_rsp_t   rsp     [2];                 // Response per bus.
   logic                o;                           // Channel owning the bus in hand.
   logic [1:0]          off;                         // Low address bits of the bus.
   logic [2:0]          n;                           // Bytes of the phase being issued.
   logic                rc;                          // Channel addressed by software.

   assign gnt[0] = pciGnt;
   assign gnt[1] = ~localGrantAckN;
   assign rsp[0] = pciRsp;
   assign rsp[1] = locRsp;

   // Every output is a field of the state register.
   assign regRdata = st_r.regRdata;
   assign pciReq   = st_r.bus[dma_pkg::BUS_PCI].req;
   assign pciCmd   = st_r.bus[dma_pkg::BUS_PCI].cmd;
   assign locReq   = st_r.bus[dma_pkg::BUS_LOCAL].req;
   assign locCmd   = st_r.bus[dma_pkg::BUS_LOCAL].cmd;

   // ------------------------------------------------------------
   // Next-state logic.
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      memWe = '0;
      push = '0;
      pop = '0;
      o = 1'b0;
      off = '0;
      n = '0;
      rdEnt = '0;
      rc = regReq.addr[dma_pkg::CH_SEL_BIT];
      for (int c = 0; c < 2; c++) begin
         memIdx[c] = '0;
         memData[c] = '0;
         freeW[c] = dma_pkg::BUF_FULL - st_r.ch[c].level;
      end

      // Thresholds; the reserved code behaves as 4/4.
      thr[dma_pkg::BUS_PCI] = (st_r.thrSel == dma_pkg::THR_16_4) ?
                              dma_pkg::THR_HIGH : dma_pkg::THR_LOW;
      thr[dma_pkg::BUS_LOCAL] = (st_r.thrSel == dma_pkg::THR_4_16) ?
                                dma_pkg::THR_HIGH : dma_pkg::THR_LOW;

      // A channel fills from the bus equal to its direction bit, flushes to the other.
      for (int b = 0; b < 2; b++) begin
         for (int c = 0; c < 2; c++) begin
            if (st_r.ch[c].dir == 1'(b)) begin
               want[b][c] = st_r.ch[c].start && st_r.ch[c].srcLeft != '0 &&
                            freeW[c] >= thr[b];
            end else begin
               want[b][c] = st_r.ch[c].start && st_r.ch[c].level != '0 &&
                            (st_r.ch[c].level >= thr[b] ||
                             st_r.ch[c].srcLeft == '0);
            end
         end
      end

      // Software write; direction only changes while the channel is stopped.
      if (regReq.wr) begin
         case (regSel(regReq.addr))
            dma_pkg::SEL_CTRL: begin
               if (!st_r.ch[rc].start) begin
                  st_nxt.ch[rc].dir = regReq.wdata[dma_pkg::CTRL_DIR_BIT];
               end
               if (!regReq.wdata[dma_pkg::CTRL_START_BIT]) begin
                  st_nxt.ch[rc].start = 1'b0;
               end else if (!st_r.ch[rc].start && st_r.ch[rc].byteCount != '0) begin
                  st_nxt.ch[rc].start = 1'b1;
                  st_nxt.ch[rc].srcLeft = st_r.ch[rc].byteCount;
                  st_nxt.ch[rc].dstLeft = st_r.ch[rc].byteCount;
                  st_nxt.ch[rc].fillOff =
                     st_r.ch[rc].addr[~regReq.wdata[dma_pkg::CTRL_DIR_BIT]][1:0];
                  st_nxt.ch[rc].wptr = '0;
                  st_nxt.ch[rc].rptr = '0;
                  st_nxt.ch[rc].level = '0;
               end
            end
            dma_pkg::SEL_HOST:  st_nxt.ch[rc].addr[dma_pkg::BUS_PCI] = regReq.wdata;
            dma_pkg::SEL_LOCAL: st_nxt.ch[rc].addr[dma_pkg::BUS_LOCAL] = regReq.wdata;
            dma_pkg::SEL_COUNT: st_nxt.ch[rc].byteCount = regReq.wdata[23:0];
            dma_pkg::SEL_CFG:   st_nxt.thrSel = regReq.wdata[dma_pkg::THR_SEL_LSB +: 2];
            default: ;
         endcase
      end
      // The configuration loader wins over a software write in the same cycle.
      if (cfgLoad) begin
         st_nxt.thrSel = cfgThrSel;
      end

      // Software read; data stand for one cycle only and read zero otherwise.
      st_nxt.regRdata = '0;
      if (regReq.rd) begin
         case (regSel(regReq.addr))
            dma_pkg::SEL_CTRL: begin
               st_nxt.regRdata[dma_pkg::CTRL_START_BIT] = st_r.ch[rc].start;
               st_nxt.regRdata[dma_pkg::CTRL_DIR_BIT] = st_r.ch[rc].dir;
               st_nxt.regRdata[dma_pkg::CTRL_LEVEL_LSB +: 6] = st_r.ch[rc].level;
            end
            dma_pkg::SEL_HOST:  st_nxt.regRdata = st_r.ch[rc].addr[dma_pkg::BUS_PCI];
            dma_pkg::SEL_LOCAL: st_nxt.regRdata = st_r.ch[rc].addr[dma_pkg::BUS_LOCAL];
            dma_pkg::SEL_COUNT: st_nxt.regRdata = {8'h00, st_r.ch[rc].dstLeft};
            dma_pkg::SEL_CFG:   st_nxt.regRdata[dma_pkg::THR_SEL_LSB +: 2] = st_r.thrSel;
            default: ;
         endcase
      end

      // One engine per bus; each moves one data phase at a time for its owner.
      for (int b = 0; b < 2; b++) begin
         o = st_r.bus[b].owner;
         off = st_r.ch[o].addr[b][1:0];
         case (st_r.bus[b].st)
            dma_pkg::BUS_IDLE: begin
               if (|want[b]) begin
                  // Both pending: the channel that did not own last goes now.
                  st_nxt.bus[b].owner = (&want[b]) ? ~st_r.bus[b].lastOwner :
                                        want[b][1];
                  st_nxt.bus[b].req = 1'b1;
                  st_nxt.bus[b].st = dma_pkg::BUS_REQ;
               end
            end
            dma_pkg::BUS_REQ: begin
               if (gnt[b]) begin
                  st_nxt.bus[b].flush = st_r.ch[o].dir != 1'(b);
                  st_nxt.bus[b].st = dma_pkg::BUS_XFER;
               end
            end
            dma_pkg::BUS_XFER: begin
               if (st_r.bus[b].cmd.valid) begin
                  if (rsp[b].stop) begin
                     // Retry or disconnect: drop the bus, the phase is redone later.
                     st_nxt.bus[b].cmd.valid = 1'b0;
                     st_nxt.bus[b].req = 1'b0;
                     st_nxt.bus[b].lastOwner = o;
                     st_nxt.bus[b].st = dma_pkg::BUS_IDLE;
                  end else if (rsp[b].ack) begin
                     st_nxt.bus[b].cmd.valid = 1'b0;
                     st_nxt.ch[o].addr[b] = st_r.ch[o].addr[b] + 32'(st_r.bus[b].n);
                     if (st_r.bus[b].flush) begin
                        st_nxt.ch[o].dstLeft = st_r.ch[o].dstLeft - 24'(st_r.bus[b].n);
                        st_nxt.ch[o].rptr = st_r.ch[o].rptr + 5'h01;
                        pop[o] = 1'b1;
                        if (st_r.ch[o].dstLeft == 24'(st_r.bus[b].n)) begin
                           st_nxt.ch[o].start = 1'b0;
                        end
                     end else begin
                        memWe[o] = 1'b1;
                        memIdx[o] = st_r.ch[o].wptr;
                        memData[o].n = st_r.bus[b].n;
                        memData[o].data = rsp[b].rdata >> {off, 3'b000};
                        st_nxt.ch[o].srcLeft = st_r.ch[o].srcLeft - 24'(st_r.bus[b].n);
                        st_nxt.ch[o].fillOff = st_r.ch[o].fillOff + st_r.bus[b].n[1:0];
                        st_nxt.ch[o].wptr = st_r.ch[o].wptr + 5'h01;
                        push[o] = 1'b1;
                     end
                  end
               end else if (!st_r.ch[o].start ||
                            (st_r.bus[b].flush ? st_r.ch[o].level == '0 :
                             (st_r.ch[o].level == dma_pkg::BUF_FULL ||
                              st_r.ch[o].srcLeft == '0))) begin
                  // Release when full or done filling, or when empty flushing.
                  st_nxt.bus[b].req = 1'b0;
                  st_nxt.bus[b].lastOwner = o;
                  st_nxt.bus[b].st = dma_pkg::BUS_IDLE;
               end else if (st_r.bus[b].flush) begin
                  rdEnt = bufMem[o][st_r.ch[o].rptr];
                  st_nxt.bus[b].n = rdEnt.n;
                  st_nxt.bus[b].cmd.addr = st_r.ch[o].addr[b];
                  st_nxt.bus[b].cmd.be = laneMask(rdEnt.n, off);
                  st_nxt.bus[b].cmd.wdata = rdEnt.data << {off, 3'b000};
                  st_nxt.bus[b].cmd.write = 1'b1;
                  st_nxt.bus[b].cmd.valid = 1'b1;
               end else begin
                  n = phaseBytes(off, st_r.ch[o].fillOff, st_r.ch[o].srcLeft);
                  st_nxt.bus[b].n = n;
                  st_nxt.bus[b].cmd.write = 1'b0;
                  st_nxt.bus[b].cmd.wdata = '0;
                  st_nxt.bus[b].cmd.valid = 1'b1;
                  if (b == dma_pkg::BUS_LOCAL) begin
                     st_nxt.bus[b].cmd.addr = {st_r.ch[o].addr[b][31:2], 2'b00};
                     st_nxt.bus[b].cmd.be = 4'hF;
                  end else begin
                     st_nxt.bus[b].cmd.addr = st_r.ch[o].addr[b];
                     st_nxt.bus[b].cmd.be = laneMask(n, off);
                  end
               end
            end
            default: st_nxt.bus[b] = '0;
         endcase
      end

      // Both buses may touch one buffer in the same cycle.
      for (int c = 0; c < 2; c++) begin
         st_nxt.ch[c].level = st_nxt.ch[c].level + 6'(push[c]) - 6'(pop[c]);
      end
   end

   // ------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= dma_pkg::STATE_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Buffer memory has no reset; the level counters say what is valid.
   always_ff @(posedge core_clk) begin
      for (int c = 0; c < 2; c++) begin
         if (memWe[c]) begin
            bufMem[c][memIdx[c]] <= memData[c];
         end
      end
   end

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence pciToLocalStart;
      $rose(st_r.ch[0].start) && !st_r.ch[0].dir && !st_r.ch[1].start &&
      st_r.bus[0].st == dma_pkg::BUS_IDLE;
   endsequence

   chk_buf_level_bound: assert property (st_r.ch[0].level <= dma_pkg::BUF_FULL &&
         st_r.ch[1].level <= dma_pkg::BUF_FULL)
      else $error("buffer level above capacity");
   chk_pci_start_req: assert property (pciToLocalStart |=> pciReq)
      else $error("pci not requested after start");
   chk_local_read_lanes: assert property (locCmd.valid && !locCmd.write |->
         locCmd.be == 4'hF && locCmd.addr[1:0] == 2'b00)
      else $error("local read not a whole word");
   chk_odd_write_lanes: assert property (locCmd.valid && locCmd.write &&
         locCmd.addr[1:0] == 2'b01 |-> !locCmd.be[0] && locCmd.be[1])
      else $error("odd local write uses wrong lanes");
   chk_pci_full_release: assert property (st_r.bus[0].st == dma_pkg::BUS_XFER &&
         !pciCmd.valid && !st_r.bus[0].flush &&
         st_r.ch[st_r.bus[0].owner].level == dma_pkg::BUF_FULL |=> !pciReq)
      else $error("pci kept while buffer full");
   chk_retry_alternate: assert property (pciCmd.valid && pciRsp.stop |=>
         !pciReq && st_r.bus[0].lastOwner == $past(st_r.bus[0].owner))
      else $error("retry did not pass ownership");
   chk_local_pending: assert property (st_r.bus[1].st == dma_pkg::BUS_IDLE &&
         &want[1] |=> locReq && st_r.bus[1].owner != st_r.bus[1].lastOwner)
      else $error("pending channel not served next");
   chk_flush_thresh: assert property ($rose(pciReq) &&
         st_r.ch[st_r.bus[0].owner].dir |->
         st_r.ch[st_r.bus[0].owner].level >= thr[0] ||
         st_r.ch[st_r.bus[0].owner].srcLeft == '0)
      else $error("pci flush requested below threshold");
   chk_run_count: assert property (st_r.ch[0].start |-> st_r.ch[0].dstLeft != '0)
      else $error("channel running with nothing left");

   // Software may not turn a running channel around; the buffer would mix directions.
   chk_dir_frozen: assert property (st_r.ch[0].start |=> $stable(st_r.ch[0].dir))
      else $error("direction changed while running");
   chk_pci_flush_release: assert property (st_r.bus[0].st == dma_pkg::BUS_XFER &&
         !pciCmd.valid && st_r.bus[0].flush &&
         st_r.ch[st_r.bus[0].owner].level == '0 |=> !pciReq)
      else $error("pci kept with buffer empty");
   chk_local_fill_room: assert property ($rose(locReq) &&
         st_r.ch[st_r.bus[1].owner].dir |->
         freeW[st_r.bus[1].owner] >= thr[1])
      else $error("local fill requested without room");
   chk_local_flush_level: assert property ($rose(locReq) &&
         !st_r.ch[st_r.bus[1].owner].dir |->
         st_r.ch[st_r.bus[1].owner].level >= thr[1] ||
         st_r.ch[st_r.bus[1].owner].srcLeft == '0)
      else $error("local flush requested below threshold");
   chk_pci_lane_start: assert property (pciCmd.valid |->
         (pciCmd.be & ~(4'hF << pciCmd.addr[1:0])) == 4'h0)
      else $error("pci lanes below the start address");

endmodule

/* File: verif/bus_target_model.sv */
// Bus partner: arbiter, target and a 256-byte memory for one side.
`timescale 1ns/100ps
module bus_target_model #(
   parameter bit         GNT_LOW = 1'b0,  // Grant polarity.
   parameter logic [7:0] PATTERN = 8'h3C, // Byte at a holds a ^ PATTERN.
   parameter logic [1:0] RETRIES = 2'h0   // First phases refused with a retry.
) (
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   input  wire logic              req,
   output logic                   gnt,
   input  wire dma_pkg::bus_cmd_t cmd,
   output dma_pkg::bus_rsp_t      rsp,
   input  wire logic              slow
);
   logic [31:0] mem [0:63];  // Word store.
   logic [1:0]  waitCnt;     // Wait before the next acknowledge.
   logic [1:0]  stopsLeft;   // Phases still to be refused.
   logic        busy;        // An answer is on the bus this cycle.
   assign busy = rsp.ack || rsp.stop;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i/4][8*(i%4) +: 8] = 8'(i) ^ PATTERN;
      end
   end
   // Read data toggle outside the answer cycle, so stale data never matches.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         gnt     <= GNT_LOW;
         rsp     <= '0;
         waitCnt <= 2'h0;
         stopsLeft <= RETRIES;
      end else begin
         gnt       <= req ^ GNT_LOW;
         rsp.ack   <= 1'b0;
         rsp.stop  <= 1'b0;
         rsp.rdata <= ~rsp.rdata;
         if (cmd.valid && !busy && waitCnt != 2'h0) begin
            waitCnt <= waitCnt - 2'h1;
         end else if (cmd.valid && !busy && stopsLeft != 2'h0) begin
            // Retry: nothing moves, the master must give up the bus and redo the phase.
            rsp.stop  <= 1'b1;
            stopsLeft <= stopsLeft - 2'h1;
         end else if (cmd.valid && !busy) begin
            rsp.ack <= 1'b1;
            waitCnt <= slow ? 2'h3 : 2'h0;
            for (int l = 0; l < 4; l++) begin
               if (cmd.write && cmd.be[l]) begin
                  mem[cmd.addr[7:2]][8*l +: 8] <= cmd.wdata[8*l +: 8];
               end
            end
            if (!cmd.write) begin
               rsp.rdata <= mem[cmd.addr[7:2]];
            end
         end
      end
   end
endmodule

/* File: verif/dual_channel_bus_master_dma_tb.sv */
// Self-checking bench for the two-channel DMA engine.
`timescale 1ns/100ps
module dual_channel_bus_master_dma_tb;
   logic core_clk, rst_b, cfgLoad, pciReq, pciGnt, locReq, localGrantAckN, slowLoc;
   logic [1:0]  cfgThrSel;
   logic [31:0] regRdata, rv;
   dma_pkg::reg_req_t regReq;
   dma_pkg::bus_cmd_t pciCmd, locCmd;
   dma_pkg::bus_rsp_t pciRsp, locRsp;
   int fails = 0, n_compared = 0, cycles = 0;
   dual_channel_bus_master_dma dut (.core_clk(core_clk), .rst_b(rst_b), .regReq(regReq),
      .regRdata(regRdata), .cfgLoad(cfgLoad), .cfgThrSel(cfgThrSel), .pciReq(pciReq),
      .pciGnt(pciGnt), .pciCmd(pciCmd), .pciRsp(pciRsp), .locReq(locReq),
      .localGrantAckN(localGrantAckN), .locCmd(locCmd), .locRsp(locRsp));
   bus_target_model #(.GNT_LOW(1'b0), .PATTERN(8'h3C), .RETRIES(2'h1))
      pciMod (.core_clk(core_clk),
      .rst_b(rst_b), .req(pciReq), .gnt(pciGnt), .cmd(pciCmd), .rsp(pciRsp), .slow(1'b0));
   bus_target_model #(.GNT_LOW(1'b1), .PATTERN(8'hC3), .RETRIES(2'h0))
      locMod (.core_clk(core_clk),
      .rst_b(rst_b), .req(locReq), .gnt(localGrantAckN), .cmd(locCmd), .rsp(locRsp),
      .slow(slowLoc));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Hang guard, far above the few hundred cycles the run needs.
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input bit ok, input string what);
      n_compared++;
      if (!ok) begin
         fails++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   // Each access leaves an idle cycle, so no strobe is assigned twice in a step.
   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      regReq <= '0;
      @(posedge core_clk);
   endtask
   task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
      regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      regReq <= '0;
      @(negedge core_clk);
      d = regRdata;
      @(posedge core_clk);
   endtask
   task automatic startCh(input logic [7:0] b, input logic [31:0] h, l, n, input bit dir);
      wrReg(b + dma_pkg::OFF_HOST, h);
      wrReg(b + dma_pkg::OFF_LOCAL, l);
      wrReg(b + dma_pkg::OFF_COUNT, n);
      wrReg(b, {30'h0, dir, 1'b1});
   endtask
   task automatic waitDone(input logic [7:0] b);
      for (int i = 0; i < 500; i++) begin
         rdReg(b, rv);
         if (rv[0] === 1'b0) break;
      end
      check(rv[0] === 1'b0, "channel never stopped");
      rdReg(b + dma_pkg::OFF_COUNT, rv);
      check(rv === 32'h0, "byte count left");
   endtask
   // Copied bytes must match the source; the bytes either side stay untouched.
   task automatic chkCopy(input bit toPci, input logic [7:0] s, d, input int n);
      logic [7:0] a, got, exp;
      for (int i = -1; i <= n; i++) begin
         a = 8'(d + i);
         got = toPci ? pciMod.mem[a[7:2]][8*a[1:0] +: 8] : locMod.mem[a[7:2]][8*a[1:0] +: 8];
         exp = (i < 0 || i >= n) ? (a ^ (toPci ? 8'h3C : 8'hC3)) :
                                   (8'(s + i) ^ (toPci ? 8'hC3 : 8'h3C));
         check(got === exp, "copied byte wrong");
      end
   endtask
   task automatic tRegs();
      rdReg(8'h00, rv);
      check(rv === 32'h0, "control not idle");
      wrReg(8'h44, 32'hFFFFFFFF);
      rdReg(8'h44, rv);
      check(rv === 32'h0, "unmapped read not zero");
      wrReg(dma_pkg::OFF_SERIAL_CFG, 32'h2);
      rdReg(dma_pkg::OFF_SERIAL_CFG, rv);
      check(rv === 32'h2, "software threshold select");
      cfgLoad <= 1'b1;
      cfgThrSel <= dma_pkg::THR_16_4;
      @(posedge core_clk);
      cfgLoad <= 1'b0;
      rdReg(dma_pkg::OFF_SERIAL_CFG, rv);
      check(rv === 32'h4, "loaded threshold select");
   endtask
   task automatic tBoth();
      startCh(8'h00, 32'h01, 32'h81, 32'd11, 1'b0);
      startCh(8'h20, 32'hC0, 32'h00, 32'd48, 1'b1);
      waitDone(8'h00);
      waitDone(8'h20);
      chkCopy(1'b0, 8'h01, 8'h81, 11);
      chkCopy(1'b1, 8'h00, 8'hC0, 48);
   endtask
   task automatic tBig();
      wrReg(dma_pkg::OFF_SERIAL_CFG, 32'h2);
      slowLoc <= 1'b1;
      startCh(8'h00, 32'h00, 32'h00, 32'd160, 1'b0);
      waitDone(8'h00);
      chkCopy(1'b0, 8'h00, 8'h00, 160);
   endtask
   initial begin
      rst_b = 1'b0;
      regReq = '0;
      cfgLoad = 1'b0;
      cfgThrSel = 2'b00;
      slowLoc = 1'b0;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      tRegs();
      tBoth();
      tBig();
      report_and_stop();
   end
endmodule
